// >>> dp_host_params.svh
`ifndef DP_HOST_PARAMS_SVH
`define DP_HOST_PARAMS_SVH

`define DP_CLK_MHZ 100
`define DP_ADDR_W 14
`define DP_DATA_W 16
`define DP_TMR_W 8

// Figures in nanoseconds.
`define DP_TWP_NS 12
`define DP_TWZ_NS 10
`define DP_TDW_NS 10
`define DP_TWH_NS 12
`define DP_TSWRD_NS 5
`define DP_TREAD_NS 35

// Least times round up to whole cycles and never drop below one.
`define DP_NS2CYC(ns) ((((ns) * `DP_CLK_MHZ + 999) / 1000) < 1 ? 1 : (((ns) * `DP_CLK_MHZ + 999) / 1000))
`define DP_TWP_CYC `DP_NS2CYC(`DP_TWP_NS)
`define DP_TWZDW_CYC `DP_NS2CYC(`DP_TWZ_NS + `DP_TDW_NS)
`define DP_TWH_CYC `DP_NS2CYC(`DP_TWH_NS)
`define DP_TSWRD_CYC `DP_NS2CYC(`DP_TSWRD_NS)
`define DP_TREAD_CYC `DP_NS2CYC(`DP_TREAD_NS)

`endif

// >>> dp_host_pkg.sv
`default_nettype none
package dp_host_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SETUP = 6'h02,
      ST_STROBE = 6'h04,
      ST_RECOVER = 6'h08,
      ST_GAP = 6'h10,
      ST_READ = 6'h20
   } host_state_t;
endpackage
`default_nettype wire

// >>> dp_wait_timer.sv
`timescale 1ns/1ps
`default_nettype none
module dp_wait_timer #(
   parameter int W = 8
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic load_i,
   input wire logic [W-1:0] value_i,
   output logic expired_o
);
   logic [W-1:0] cnt_q;

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         cnt_q <= '0;
      end else if (load_i) begin
         cnt_q <= value_i;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign expired_o = (cnt_q == '0);
endmodule
`default_nettype wire

// >>> dp_port_host.sv
// Contract
// - Array: enable low, flag select high; flags: reverse; held through write.
// - Strobe, enable or both byte selects high whenever address changes.
// - Host never drives data while device outputs are active.
// - Write pulse covers turn-off plus set-up when output enable is low.
// - Port enable high through semaphore write and its read-back.
// - Slave busy input applied no later than start of write strobe; code forwards busy_n_i to slave_busy_n_o one cycle late.
// - Write strobe held for write-hold interval after busy release.
`timescale 1ns/1ps
`default_nettype none
`include "dp_host_params.svh"
module dp_port_host
   import dp_host_pkg::*;
#(
   parameter int AW = `DP_ADDR_W,
   parameter int DW = `DP_DATA_W,
   parameter bit OE_LOW_ON_WRITE = 1'b0
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic req_i,
   input wire logic write_i,
   input wire logic flag_op_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wdata_i,
   input wire logic [1:0] byte_en_i,
   output logic ready_o,
   output logic done_o,
   output logic [DW-1:0] rdata_o,
   output logic flag_won_o,
   output logic ce_n_o,
   output logic rw_n_o,
   output logic oe_n_o,
   output logic flag_select_n_o,
   output logic high_byte_sel_n_o,
   output logic low_byte_sel_n_o,
   output logic [AW-1:0] addr_o,
   output logic [DW-1:0] data_o,
   output logic data_oe_o,
   input wire logic [DW-1:0] data_i,
   input wire logic busy_n_i,
   output logic slave_busy_n_o
);
   localparam logic [`DP_TMR_W-1:0] TWP_C = `DP_TMR_W'(`DP_TWP_CYC);
   localparam logic [`DP_TMR_W-1:0] TWZDW_C = `DP_TMR_W'(`DP_TWZDW_CYC);
   localparam logic [`DP_TMR_W-1:0] TWH_C = `DP_TMR_W'(`DP_TWH_CYC);
   localparam logic [`DP_TMR_W-1:0] TSWRD_C = `DP_TMR_W'(`DP_TSWRD_CYC);
   localparam logic [`DP_TMR_W-1:0] TREAD_C = `DP_TMR_W'(`DP_TREAD_CYC);
   localparam logic [`DP_TMR_W-1:0] PULSE_C = (OE_LOW_ON_WRITE && TWZDW_C > TWP_C) ? TWZDW_C : TWP_C;

   host_state_t state_q;
   logic is_write_q;
   logic is_flag_q;
   logic [1:0] be_q;
   logic blocked_q;
   logic tmr_load;
   logic [`DP_TMR_W-1:0] tmr_val;
   logic tmr_done;

   // Busy stalls array writes only, since the flags have no address arbitration behind them.
   function automatic logic busy_stalls(input logic busy_n, input logic flag_op);
      return !busy_n && !flag_op;
   endfunction

   dp_wait_timer #(
      .W(`DP_TMR_W)
   ) u_timer (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .load_i(tmr_load),
      .value_i(tmr_val),
      .expired_o(tmr_done)
   );

   always_comb begin
      tmr_load = 1'b0;
      tmr_val = '0;
      case (state_q)
         ST_SETUP: begin
            tmr_load = 1'b1;
            tmr_val = is_write_q ? PULSE_C : TREAD_C;
         end
         ST_STROBE: begin
            if (busy_stalls(busy_n_i, is_flag_q)) begin
               tmr_load = 1'b1;
               tmr_val = TWH_C;
            end
         end
         ST_RECOVER: begin
            tmr_load = 1'b1;
            tmr_val = TSWRD_C;
         end
         default: begin
            tmr_load = 1'b0;
            tmr_val = '0;
         end
      endcase
   end

   // Busy from the master is registered every cycle, so it reaches slave_busy_n_o one cycle late and can trail the start of a strobe.
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         slave_busy_n_o <= 1'b1;
      end else begin
         slave_busy_n_o <= busy_n_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         state_q <= ST_IDLE;
         is_write_q <= 1'b0;
         is_flag_q <= 1'b0;
         be_q <= 2'h0;
         blocked_q <= 1'b0;
         ready_o <= 1'b1;
         done_o <= 1'b0;
         rdata_o <= '0;
         flag_won_o <= 1'b0;
         ce_n_o <= 1'b1;
         rw_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         flag_select_n_o <= 1'b1;
         high_byte_sel_n_o <= 1'b1;
         low_byte_sel_n_o <= 1'b1;
         addr_o <= '0;
         data_o <= '0;
         data_oe_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (req_i) begin
                  // Address moves only while every strobe is high.
                  addr_o <= addr_i;
                  is_write_q <= write_i;
                  is_flag_q <= flag_op_i;
                  be_q <= flag_op_i ? 2'h3 : byte_en_i;
                  data_o <= wdata_i;
                  ready_o <= 1'b0;
                  blocked_q <= 1'b0;
                  state_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               ce_n_o <= is_flag_q;
               flag_select_n_o <= !is_flag_q;
               high_byte_sel_n_o <= !be_q[1];
               low_byte_sel_n_o <= !be_q[0];
               if (is_write_q) begin
                  // Strobe falls with the enable or flag select so the device stays off the bus.
                  rw_n_o <= 1'b0;
                  oe_n_o <= !OE_LOW_ON_WRITE;
                  data_oe_o <= 1'b1;
                  state_q <= ST_STROBE;
               end else begin
                  oe_n_o <= 1'b0;
                  data_oe_o <= 1'b0;
                  state_q <= ST_READ;
               end
            end
            ST_STROBE: begin
               if (busy_stalls(busy_n_i, is_flag_q)) begin
                  blocked_q <= 1'b1;
               end else if (tmr_done) begin
                  // Enable, strobe and selects rise together; condition held to the end.
                  rw_n_o <= 1'b1;
                  ce_n_o <= 1'b1;
                  flag_select_n_o <= 1'b1;
                  high_byte_sel_n_o <= 1'b1;
                  low_byte_sel_n_o <= 1'b1;
                  oe_n_o <= 1'b1;
                  state_q <= ST_RECOVER;
               end
            end
            ST_RECOVER: begin
               data_oe_o <= 1'b0;
               if (is_flag_q) begin
                  is_write_q <= 1'b0;
                  state_q <= ST_GAP;
               end else begin
                  done_o <= 1'b1;
                  ready_o <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            ST_GAP: begin
               // Read-back of the flag keeps the array enable high throughout.
               if (tmr_done) begin
                  state_q <= ST_SETUP;
               end
            end
            ST_READ: begin
               if (tmr_done) begin
                  rdata_o <= data_i;
                  flag_won_o <= is_flag_q && !data_i[0];
                  ce_n_o <= 1'b1;
                  oe_n_o <= 1'b1;
                  flag_select_n_o <= 1'b1;
                  high_byte_sel_n_o <= 1'b1;
                  low_byte_sel_n_o <= 1'b1;
                  done_o <= 1'b1;
                  ready_o <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> dp_host_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dp_host_assertions #(
   parameter int AW = 14
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic busy_n_i,
   input wire logic done_o,
   input wire logic ce_n_o,
   input wire logic rw_n_o,
   input wire logic oe_n_o,
   input wire logic flag_select_n_o,
   input wire logic data_oe_o,
   input wire logic slave_busy_n_o,
   input wire logic [AW-1:0] addr_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_no_bus_fight: assert property (data_oe_o |-> oe_n_o) else $error("host drives under output enable");
   a_addr_hold: assert property (!rw_n_o |-> $stable(addr_o)) else $error("address moved in strobe");
   a_addr_quiet: assert property ($changed(addr_o) |-> rw_n_o && ce_n_o && flag_select_n_o)
      else $error("address moved while selected");
   a_ram_select: assert property (!ce_n_o |-> flag_select_n_o) else $error("both selects low");
   a_flag_select: assert property (!flag_select_n_o |-> ce_n_o) else $error("enable low on flag access");
   a_pulse_width: assert property ($fell(rw_n_o) |-> (!rw_n_o && data_oe_o) [*2]) else $error("short pulse");
   a_busy_hold: assert property ($rose(busy_n_i) && !rw_n_o && !ce_n_o |=> !rw_n_o) else $error("no hold");
   a_slave_busy: assert property (!busy_n_i |=> !slave_busy_n_o) else $error("busy not passed on");
   a_done_quiet: assert property (done_o |-> ce_n_o && rw_n_o && flag_select_n_o && !data_oe_o) else $error("done");
   a_read_access: assert property ($fell(oe_n_o) |-> (rw_n_o && !oe_n_o) [*3]) else $error("short read");
   c_write: cover property ($fell(rw_n_o) && !ce_n_o);
   c_flag: cover property (!flag_select_n_o && !rw_n_o);
   c_busy: cover property ($rose(busy_n_i) && !rw_n_o);
endmodule
bind dp_port_host dp_host_assertions #(.AW(AW)) u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .busy_n_i(busy_n_i),
   .done_o(done_o), .ce_n_o(ce_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o), .flag_select_n_o(flag_select_n_o),
   .data_oe_o(data_oe_o), .slave_busy_n_o(slave_busy_n_o), .addr_o(addr_o));
`default_nettype wire

// >>> dp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dp_dev_model (
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic rw_n_i,
   input wire logic oe_n_i,
   input wire logic flag_select_n_i,
   input wire logic high_byte_sel_n_i,
   input wire logic low_byte_sel_n_i,
   input wire logic busy_n_i,
   input wire logic other_i,
   input wire logic [13:0] addr_i,
   input wire logic [15:0] data_i,
   output logic [15:0] data_o
);
   logic [15:0] mem_q [0:15];
   logic [7:0] flag_q = 8'hff;
   logic [15:0] last_q = 16'h0000;
   wire logic drive = !oe_n_i && rw_n_i && (!ce_n_i || !flag_select_n_i);
   always @(posedge clk_i) begin
      if (!ce_n_i && !rw_n_i && busy_n_i) begin
         if (!low_byte_sel_n_i) mem_q[addr_i[3:0]][7:0] <= data_i[7:0];
         if (!high_byte_sel_n_i) mem_q[addr_i[3:0]][15:8] <= data_i[15:8];
      end
      // A token held by the far port keeps the flag set, so only one side wins.
      if (!flag_select_n_i && !rw_n_i) flag_q[addr_i[2:0]] <= data_i[0] | other_i;
      if (drive) last_q <= data_o;
   end
   // A released bus shows the inverse of its last value, never a stale copy.
   assign data_o = !drive ? ~last_q : !ce_n_i ? mem_q[addr_i[3:0]] : {16{flag_q[addr_i[2:0]]}};
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; $display("Error t=%0t %h %h", $time, a, b); end end
module testbench;
   logic clk_i = 1'b0, resetn_i = 1'b0, req_i = 1'b0, write_i = 1'b0, flag_op_i = 1'b0;
   logic busy_n_i = 1'b1, other = 1'b0;
   logic [13:0] addr_i = 14'h0000, addr_o;
   logic [15:0] wdata_i = 16'h0000, rdata_o, data_o, data_i, dev_q;
   logic [1:0] byte_en_i = 2'h3;
   logic ready_o, done_o, flag_won_o, ce_n_o, rw_n_o, oe_n_o, flag_select_n_o;
   logic high_byte_sel_n_o, low_byte_sel_n_o, data_oe_o, slave_busy_n_o;
   int num_errors = 0, checked = 0, cycles = 0;
   assign data_i = data_oe_o ? data_o : dev_q;
   initial forever #5 clk_i = ~clk_i;
   dp_port_host DUT (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .write_i(write_i), .flag_op_i(flag_op_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .byte_en_i(byte_en_i), .ready_o(ready_o), .done_o(done_o),
      .rdata_o(rdata_o), .flag_won_o(flag_won_o), .ce_n_o(ce_n_o), .rw_n_o(rw_n_o), .oe_n_o(oe_n_o),
      .flag_select_n_o(flag_select_n_o), .high_byte_sel_n_o(high_byte_sel_n_o),
      .low_byte_sel_n_o(low_byte_sel_n_o), .addr_o(addr_o), .data_o(data_o), .data_oe_o(data_oe_o),
      .data_i(data_i), .busy_n_i(busy_n_i), .slave_busy_n_o(slave_busy_n_o));
   dp_dev_model dev (.clk_i(clk_i), .ce_n_i(ce_n_o), .rw_n_i(rw_n_o), .oe_n_i(oe_n_o),
      .flag_select_n_i(flag_select_n_o), .high_byte_sel_n_i(high_byte_sel_n_o),
      .low_byte_sel_n_i(low_byte_sel_n_o), .busy_n_i(busy_n_i), .other_i(other),
      .addr_i(addr_o), .data_i(data_i), .data_o(dev_q));
   task give_verdict;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end
   task cmd(input logic w, input logic s, input logic [13:0] a, input logic [15:0] d, input logic [1:0] b);
      req_i <= 1'b1;
      write_i <= w;
      flag_op_i <= s;
      addr_i <= a;
      wdata_i <= d;
      byte_en_i <= b;
      @(posedge clk_i);
      req_i <= 1'b0;
      do @(posedge clk_i); while (done_o !== 1'b1);
   endtask
   task t_ram;
      cmd(1'b1, 1'b0, 14'h0003, 16'ha5c3, 2'h3);
      `CHK(ready_o, 1'b1)
      cmd(1'b1, 1'b0, 14'h0003, 16'h0f0f, 2'h1);
      cmd(1'b0, 1'b0, 14'h0003, 16'h0000, 2'h3);
      `CHK(rdata_o, 16'ha50f)
   endtask
   task t_busy;
      busy_n_i <= 1'b0;
      fork
         cmd(1'b1, 1'b0, 14'h0005, 16'h1234, 2'h3);
         begin
            repeat (12) @(posedge clk_i);
            `CHK(rw_n_o, 1'b0)
            `CHK(slave_busy_n_o, 1'b0)
            busy_n_i <= 1'b1;
         end
      join
      cmd(1'b0, 1'b0, 14'h0005, 16'h0000, 2'h3);
      `CHK(rdata_o, 16'h1234)
   endtask
   task t_flag;
      for (int i = 0; i < 2; i++) begin
         other <= i[0];
         cmd(1'b1, 1'b1, 14'h0002, 16'h0000, 2'h3);
         `CHK(flag_won_o, ~i[0])
         `CHK(rdata_o, {16{i[0]}})
      end
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      resetn_i <= 1'b1;
      t_ram();
      t_busy();
      t_flag();
      give_verdict();
   end
endmodule
`default_nettype wire
